/* File: verilog/sba_bus_control_unit.sv */
// Function
// - separate processor and dma request inputs, refresh request raised internally
// - exactly one requester granted, others wait
// - granted cycle never preempted by others
// - abort cycles longer than limit, free bus
// - idle bus grants lone request at once
// - refresh beats dma within dma class
// - contended classes alternate, previous owner loses
// - refresh request raised every fixed interval
// - refresh cycle dataless, blocks memory access
// - dma controllers share open-collector request line
// - acknowledge daisy chained, nearest controller wins
// - dma transfer waits for acknowledge
// - processor requests during any bus access but its own
// - processor transfer type known, starts on acknowledge
// - one word per allocation, then release
// - transfer handshake handled without the arbiter
// - timer starts at allocation, cleared by done
// - aborted cycle raises internal trap level
module sba_bus_control_unit #(
  parameter logic [sba_pkg::CNT_W-1:0] REFRESH_CYCLES = sba_pkg::REFRESH_CYCLES,
  parameter logic [sba_pkg::CNT_W-1:0] TIMEOUT_CYCLES = sba_pkg::TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  // bus side
  sba_bus_if.device bus,
  // status toward the processor
  output logic      refresh_pending_o,
  output logic      bus_busy_o
);
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CPU,
    ST_DMA,
    ST_REF,
    ST_RELEASE
  } sba_state_e;

  // synchroniser stages: bit 0 processor, 1 dma, 2 done
  logic [2:0]                    sync1_reg;
  logic [2:0]                    sync2_reg;
  logic                          cpu_req;
  logic                          dma_req;
  logic                          done_seen;

  sba_state_e                    state_reg,    state_next;
  logic [sba_pkg::CNT_W-1:0]     timer_reg,    timer_next;
  logic [sba_pkg::CNT_W-1:0]     ref_cnt_reg,  ref_cnt_next;
  logic [sba_pkg::REL_W-1:0]     rel_cnt_reg,  rel_cnt_next;
  logic                          ref_pend_reg, ref_pend_next;
  logic                          last_dma_reg, last_dma_next;
  logic                          cpu_gnt_reg,  cpu_gnt_next;
  logic                          dma_gnt_reg,  dma_gnt_next;
  logic                          ref_gnt_reg,  ref_gnt_next;
  logic                          abort_reg,    abort_next;
  logic                          trap_reg,     trap_next;
  logic [sba_pkg::LEVEL_W-1:0]   level_reg,    level_next;
  logic                          busy_reg,     busy_next;
  logic                          ref_tick;
  logic                          dma_class;
  logic                          pick_dma;

  // requests are asynchronous to this clock; only stage two is read
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {bus.transfer_done_strobe, ~bus.dma_bus_request_n,
                    bus.cpu_bus_request};
      sync2_reg <= sync1_reg;
    end
  end

  assign cpu_req   = sync2_reg[0];
  assign dma_req   = sync2_reg[1];
  assign done_seen = sync2_reg[2];

  // refresh oscillator; a tick in the grant cycle wins over the clear
  always_comb begin
    ref_tick      = (ref_cnt_reg == REFRESH_CYCLES - sba_pkg::CNT_ONE);
    ref_cnt_next  = ref_tick ? sba_pkg::CNT_ZERO : ref_cnt_reg + sba_pkg::CNT_ONE;
    ref_pend_next = ref_pend_reg;
    if (state_next == ST_REF && state_reg == ST_IDLE) begin
      ref_pend_next = 1'b0;
    end
    if (ref_tick) begin
      ref_pend_next = 1'b1;
    end
  end

  // allocation and cycle supervision
  always_comb begin
    state_next    = state_reg;
    timer_next    = timer_reg;
    rel_cnt_next  = rel_cnt_reg;
    last_dma_next = last_dma_reg;
    abort_next    = 1'b0;
    trap_next     = 1'b0;
    level_next    = level_reg;
    dma_class     = ref_pend_reg | dma_req;
    pick_dma      = dma_class;
    if (dma_class && cpu_req) begin
      pick_dma = ~last_dma_reg;
    end
    unique case (state_reg)
      ST_IDLE: begin
        timer_next = sba_pkg::CNT_ZERO;
        if (pick_dma) begin
          state_next    = ref_pend_reg ? ST_REF : ST_DMA;
          last_dma_next = 1'b1;
        end else if (cpu_req) begin
          state_next    = ST_CPU;
          last_dma_next = 1'b0;
        end
      end
      ST_CPU, ST_DMA, ST_REF: begin
        // no branch here looks at other requests
        timer_next = timer_reg + sba_pkg::CNT_ONE;
        if (done_seen) begin
          state_next   = ST_RELEASE;
          rel_cnt_next = sba_pkg::REL_ZERO;
        end else if (timer_reg == TIMEOUT_CYCLES - sba_pkg::CNT_ONE) begin
          state_next   = ST_RELEASE;
          rel_cnt_next = sba_pkg::REL_ZERO;
          abort_next   = 1'b1;
          trap_next    = 1'b1;
          level_next   = sba_pkg::TRAP_LEVEL;
        end
      end
      ST_RELEASE: begin
        timer_next   = sba_pkg::CNT_ZERO;
        rel_cnt_next = rel_cnt_reg + sba_pkg::REL_ONE;
        if (rel_cnt_reg == sba_pkg::RELEASE_CYCLES - sba_pkg::REL_ONE) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // one grant at a time follows from the single state
  always_comb begin
    cpu_gnt_next = (state_next == ST_CPU);
    dma_gnt_next = (state_next == ST_DMA);
    ref_gnt_next = (state_next == ST_REF);
    busy_next    = cpu_gnt_next | dma_gnt_next | ref_gnt_next;
  end

  // free running: bus traffic delays a refresh grant, never the period
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ref_cnt_reg  <= '0;
      ref_pend_reg <= 1'b0;
    end else begin
      ref_cnt_reg  <= ref_cnt_next;
      ref_pend_reg <= ref_pend_next;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg    <= ST_IDLE;
      timer_reg    <= '0;
      rel_cnt_reg  <= '0;
      last_dma_reg <= 1'b0;
      abort_reg    <= 1'b0;
      trap_reg     <= 1'b0;
      level_reg    <= '0;
    end else begin
      state_reg    <= state_next;
      timer_reg    <= timer_next;
      rel_cnt_reg  <= rel_cnt_next;
      last_dma_reg <= last_dma_next;
      abort_reg    <= abort_next;
      trap_reg     <= trap_next;
      level_reg    <= level_next;
    end
  end

  // busy is a flop of its own so the status pin carries no gate
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpu_gnt_reg <= 1'b0;
      dma_gnt_reg <= 1'b0;
      ref_gnt_reg <= 1'b0;
      busy_reg    <= 1'b0;
    end else begin
      cpu_gnt_reg <= cpu_gnt_next;
      dma_gnt_reg <= dma_gnt_next;
      ref_gnt_reg <= ref_gnt_next;
      busy_reg    <= busy_next;
    end
  end

  assign bus.cpu_grant     = cpu_gnt_reg;
  assign bus.dma_grant     = dma_gnt_reg;
  assign bus.refresh_grant = ref_gnt_reg;
  assign bus.bus_abort     = abort_reg;
  assign bus.internal_trap = trap_reg;
  assign bus.trap_level    = level_reg;
  assign refresh_pending_o = ref_pend_reg;
  assign bus_busy_o        = busy_reg;
endmodule

/* File: verilog/sba_pkg.sv */
package sba_pkg;
  // clock and documented times
  localparam int unsigned CLK_MHZ           = 250;
  localparam int unsigned REFRESH_PERIOD_NS = 15000;
  localparam int unsigned CYCLE_LIMIT_NS    = 8000;

  // periodic request: nominal period, cycle limit: longest time, rounded down
  localparam int unsigned REFRESH_COUNT = REFRESH_PERIOD_NS * CLK_MHZ / 1000;
  localparam int unsigned LIMIT_COUNT   = CYCLE_LIMIT_NS * CLK_MHZ / 1000;

  localparam int unsigned CNT_W = 12;
  localparam logic [CNT_W-1:0] REFRESH_CYCLES = REFRESH_COUNT[CNT_W-1:0];
  localparam logic [CNT_W-1:0] TIMEOUT_CYCLES = LIMIT_COUNT[CNT_W-1:0];
  localparam logic [CNT_W-1:0] CNT_ZERO       = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE        = 12'h001;

  // quiet gap after a cycle so a dropped done strobe clears the synchroniser
  localparam int unsigned REL_W = 3;
  localparam logic [REL_W-1:0] RELEASE_CYCLES = 3'h4;
  localparam logic [REL_W-1:0] REL_ZERO       = 3'h0;
  localparam logic [REL_W-1:0] REL_ONE        = 3'h1;

  // internal trap level reported on a timed-out cycle
  localparam int unsigned LEVEL_W = 4;
  localparam logic [LEVEL_W-1:0] TRAP_LEVEL = 4'he;

  // processor transfer kinds
  localparam int unsigned XFER_W = 3;
  typedef enum logic [XFER_W-1:0] {
    SBA_XFER_FETCH,
    SBA_XFER_OPERAND_READ,
    SBA_XFER_INDIRECT_READ,
    SBA_XFER_OPERAND_STORE,
    SBA_XFER_IO_ACCESS,
    SBA_XFER_CTRL_REG_ACCESS
  } sba_xfer_e;

  localparam int unsigned N_DMA = 4;
endpackage

/* File: verilog/sba_bus_if.sv */
interface sba_bus_if #(
  parameter int unsigned N_DMA = sba_pkg::N_DMA
);
  // requests
  logic                               cpu_bus_request;
  logic [N_DMA-1:0]                   dma_req_oe;
  logic                               dma_bus_request_n;
  // grants and cycle end
  logic                               cpu_grant;
  logic                               dma_grant;
  logic                               refresh_grant;
  logic                               transfer_done_strobe;
  logic                               bus_abort;
  logic                               internal_trap;
  logic [sba_pkg::LEVEL_W-1:0]        trap_level;

  // open-collector request line: low while any controller drives it
  assign dma_bus_request_n = ~(|dma_req_oe);

  modport device (
    input  cpu_bus_request,
    input  dma_bus_request_n,
    input  transfer_done_strobe,
    output cpu_grant,
    output dma_grant,
    output refresh_grant,
    output bus_abort,
    output internal_trap,
    output trap_level
  );

  modport user (
    output cpu_bus_request,
    output dma_req_oe,
    output transfer_done_strobe,
    input  cpu_grant,
    input  dma_grant,
    input  refresh_grant,
    input  bus_abort,
    input  internal_trap,
    input  trap_level
  );
endinterface

/* File: verilog/sba_bus_requestors.sv */
module sba_bus_requestors #(
  parameter int unsigned N_DMA = sba_pkg::N_DMA
) (
  // clock and reset
  input  wire logic                          sys_clk_i,
  input  wire logic                          reset_n_i,
  // bus side
  sba_bus_if.user                            bus,
  // processor microprogram side
  input  wire logic                          cpu_access_i,
  input  wire logic [sba_pkg::XFER_W-1:0]    cpu_xfer_type_i,
  output logic                               cpu_xfer_start_o,
  output logic [sba_pkg::XFER_W-1:0]         cpu_xfer_type_o,
  output logic                               cpu_busy_o,
  // dma controller side, index 0 nearest the arbiter
  input  wire logic [N_DMA-1:0]              dma_need_i,
  output logic [N_DMA-1:0]                   dma_xfer_start_o,
  output logic [N_DMA-1:0]                   dma_busy_o,
  // accessed memory or interface
  input  wire logic                          mem_done_i
);
  logic                        cpu_req_reg,   cpu_req_next;
  logic                        cpu_busy_reg,  cpu_busy_next;
  logic                        cpu_start_reg, cpu_start_next;
  logic [sba_pkg::XFER_W-1:0]  cpu_type_reg,  cpu_type_next;
  logic                        cpu_gnt_d_reg;
  logic                        dma_gnt_d_reg;
  logic [N_DMA-1:0]            dma_req_reg,   dma_req_next;
  logic [N_DMA-1:0]            dma_busy_reg,  dma_busy_next;
  logic [N_DMA-1:0]            dma_start_reg, dma_start_next;
  logic                        done_reg;
  logic [N_DMA:0]              chain_in;
  logic [N_DMA-1:0]            chain_take;
  logic                        cpu_new_grant;
  logic                        dma_new_grant;

  // only the first edge of a grant is accepted; the request drops then
  assign cpu_new_grant = bus.cpu_grant & ~cpu_gnt_d_reg;
  assign dma_new_grant = bus.dma_grant & ~dma_gnt_d_reg;

  // acknowledge ripples down the chain, stopped by the first requester
  assign chain_in[0] = dma_new_grant;
  for (genvar k = 0; k < N_DMA; k++) begin : g_chain
    assign chain_take[k]   = chain_in[k] & dma_req_reg[k];
    assign chain_in[k + 1] = chain_in[k] & ~dma_req_reg[k];
  end

  always_comb begin
    cpu_req_next   = cpu_req_reg;
    cpu_busy_next  = cpu_busy_reg;
    cpu_type_next  = cpu_type_reg;
    cpu_start_next = 1'b0;
    if (cpu_access_i && !cpu_req_reg && !cpu_busy_reg) begin
      cpu_req_next  = 1'b1;
      cpu_type_next = cpu_xfer_type_i;
    end
    if (cpu_req_reg && cpu_new_grant) begin
      cpu_req_next   = 1'b0;
      cpu_busy_next  = 1'b1;
      cpu_start_next = 1'b1;
    end
    if (cpu_busy_reg && !bus.cpu_grant) begin
      cpu_busy_next = 1'b0;
    end
  end

  always_comb begin
    dma_req_next   = dma_req_reg;
    dma_busy_next  = dma_busy_reg;
    dma_start_next = '0;
    for (int k = 0; k < N_DMA; k++) begin
      if (dma_need_i[k] && !dma_req_reg[k] && !dma_busy_reg[k]) begin
        dma_req_next[k] = 1'b1;
      end
      if (chain_take[k]) begin
        dma_req_next[k]   = 1'b0;
        dma_busy_next[k]  = 1'b1;
        dma_start_next[k] = 1'b1;
      end
      if (dma_busy_reg[k] && !bus.dma_grant) begin
        dma_busy_next[k] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cpu_req_reg   <= 1'b0;
      cpu_busy_reg  <= 1'b0;
      cpu_start_reg <= 1'b0;
      cpu_type_reg  <= '0;
      cpu_gnt_d_reg <= 1'b0;
      dma_gnt_d_reg <= 1'b0;
      dma_req_reg   <= '0;
      dma_busy_reg  <= '0;
      dma_start_reg <= '0;
      done_reg      <= 1'b0;
    end else begin
      cpu_req_reg   <= cpu_req_next;
      cpu_busy_reg  <= cpu_busy_next;
      cpu_start_reg <= cpu_start_next;
      cpu_type_reg  <= cpu_type_next;
      cpu_gnt_d_reg <= bus.cpu_grant;
      dma_gnt_d_reg <= bus.dma_grant;
      dma_req_reg   <= dma_req_next;
      dma_busy_reg  <= dma_busy_next;
      dma_start_reg <= dma_start_next;
      done_reg      <= mem_done_i;
    end
  end

  assign bus.cpu_bus_request      = cpu_req_reg;
  assign bus.dma_req_oe           = dma_req_reg;
  assign bus.transfer_done_strobe = done_reg;
  assign cpu_xfer_start_o         = cpu_start_reg;
  assign cpu_xfer_type_o          = cpu_type_reg;
  assign cpu_busy_o               = cpu_busy_reg;
  assign dma_xfer_start_o         = dma_start_reg;
  assign dma_busy_o               = dma_busy_reg;
endmodule

/* File: bench/sba_bus_monitor.sv */
module sba_bus_monitor #(
  parameter logic [sba_pkg::CNT_W-1:0] TIMEOUT_CYCLES = sba_pkg::TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        reset_n_i,
  // requests and cycle end
  input  wire logic                        cpu_bus_request,
  input  wire logic                        dma_bus_request_n,
  input  wire logic                        transfer_done_strobe,
  // grants and abort
  input  wire logic                        cpu_grant,
  input  wire logic                        dma_grant,
  input  wire logic                        refresh_grant,
  input  wire logic                        bus_abort,
  input  wire logic                        internal_trap,
  input  wire logic [sba_pkg::LEVEL_W-1:0] trap_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // one spare bit so the age never wraps before the limit
  localparam logic [sba_pkg::CNT_W:0] LIMIT = {1'b0, TIMEOUT_CYCLES};
  logic                    any_grant;
  logic [sba_pkg::CNT_W:0] age_reg;
  logic [sba_pkg::CNT_W:0] age_next;

  assign any_grant = cpu_grant | dma_grant | refresh_grant;

  always_comb begin
    age_next = any_grant ? age_reg + 13'h0001 : 13'h0000;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      age_reg <= 13'h0000;
    end else begin
      age_reg <= age_next;
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  single_grant_a: assert property ($onehot0({cpu_grant, dma_grant, refresh_grant}))
    else $error("more than one grant");
  grant_hold_a: assert property ($fell(any_grant) |-> bus_abort || $past(transfer_done_strobe, 3))
    else $error("grant dropped without done or abort");
  abort_time_a: assert property (bus_abort |-> age_reg >= LIMIT && age_reg <= LIMIT + 13'h0001)
    else $error("abort at wrong cycle length");
  timer_bound_a: assert property (any_grant |-> age_reg <= LIMIT)
    else $error("cycle outlived the limit");
  abort_frees_a: assert property (bus_abort |-> !any_grant ##1 !any_grant)
    else $error("bus not freed by abort");
  trap_pair_a: assert property (internal_trap == bus_abort)
    else $error("trap and abort differ");
  trap_level_a: assert property (bus_abort |=> trap_level == sba_pkg::TRAP_LEVEL && !bus_abort)
    else $error("trap level or abort pulse wrong");
  release_gap_a: assert property ($fell(any_grant) |-> !any_grant [*4])
    else $error("grant inside release gap");
  cpu_cause_a: assert property ($rose(cpu_grant) |-> $past(cpu_bus_request, 3))
    else $error("processor grant without request");
  dma_cause_a: assert property ($rose(dma_grant) |-> !$past(dma_bus_request_n, 3))
    else $error("dma grant without request");
endmodule

/* File: bench/system_bus_allocation_arbiter_tb.sv */
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin n_fail++; \
  $display("[FAIL] %0t got %h want %h", $time, act, exp); end end

module system_bus_allocation_arbiter_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short counts keep refresh and timeout inside the run
  localparam logic [sba_pkg::CNT_W-1:0] REF = 12'h028;
  localparam logic [sba_pkg::CNT_W-1:0] TMO = 12'h032;
  localparam int LIM = 400;
  logic       sys_clk_i = 1'b0;
  logic       reset_n_i, cpu_access_i, cpu_xfer_start_o, cpu_busy_o, mem_done_i, mem_ok;
  logic       refresh_pending_o, bus_busy_o;
  logic [2:0] cpu_xfer_type_i, cpu_xfer_type_o;
  logic [3:0] dma_need_i, dma_xfer_start_o, dma_busy_o;
  int         n_fail, samples_checked, i, n;

  always #2 sys_clk_i = ~sys_clk_i;
  // memory answers any granted cycle unless told to hang
  always @(negedge sys_clk_i) mem_done_i <= mem_ok & bus_busy_o;

  sba_bus_if #(.N_DMA(4)) u_bus_if ();
  sba_bus_control_unit #(.REFRESH_CYCLES(REF), .TIMEOUT_CYCLES(TMO)) u_sba_bus_control_unit (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus(u_bus_if.device),
    .refresh_pending_o(refresh_pending_o), .bus_busy_o(bus_busy_o));
  sba_bus_requestors #(.N_DMA(4)) u_sba_bus_requestors (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .bus(u_bus_if.user),
    .cpu_access_i(cpu_access_i), .cpu_xfer_type_i(cpu_xfer_type_i),
    .cpu_xfer_start_o(cpu_xfer_start_o), .cpu_xfer_type_o(cpu_xfer_type_o),
    .cpu_busy_o(cpu_busy_o), .dma_need_i(dma_need_i), .dma_xfer_start_o(dma_xfer_start_o),
    .dma_busy_o(dma_busy_o), .mem_done_i(mem_done_i));
  sba_bus_monitor #(.TIMEOUT_CYCLES(TMO)) u_sba_bus_monitor (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cpu_bus_request(u_bus_if.cpu_bus_request),
    .dma_bus_request_n(u_bus_if.dma_bus_request_n),
    .transfer_done_strobe(u_bus_if.transfer_done_strobe), .cpu_grant(u_bus_if.cpu_grant),
    .dma_grant(u_bus_if.dma_grant), .refresh_grant(u_bus_if.refresh_grant),
    .bus_abort(u_bus_if.bus_abort), .internal_trap(u_bus_if.internal_trap),
    .trap_level(u_bus_if.trap_level));

  task automatic stop_test();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic give_up(input int cnt);
    if (cnt >= LIM) begin
      n_fail++;
      $display("[FAIL] %0t wait ran out", $time);
      stop_test();
    end
  endtask

  // requests stay up until the requestor has latched them
  task automatic ask(input logic cpu, input logic [3:0] need, input logic [2:0] kind);
    cpu_xfer_type_i = kind;
    cpu_access_i = cpu;
    dma_need_i = need;
    for (i = 0; i < LIM && (((u_bus_if.dma_req_oe & need) != need)
         || (cpu && !u_bus_if.cpu_bus_request)); i++) @(negedge sys_clk_i);
    give_up(i);
    cpu_access_i = 1'b0;
    dma_need_i = 4'h0;
  endtask

  task automatic wait_start();
    for (i = 0; i < LIM && !cpu_xfer_start_o && dma_xfer_start_o == 4'h0; i++)
      @(negedge sys_clk_i);
    give_up(i);
  endtask

  task automatic cpu_word(input logic [2:0] kind);
    ask(1'b1, 4'h0, kind);
    wait_start();
    `CHK(cpu_xfer_type_o, kind)
    `CHK(u_bus_if.cpu_grant, 1'b1)
    `CHK(dma_xfer_start_o, 4'h0)
    `CHK(cpu_busy_o, 1'b1)
    `CHK(bus_busy_o, 1'b1)
    for (i = 0; i < LIM && u_bus_if.cpu_grant; i++) @(negedge sys_clk_i);
    give_up(i);
  endtask

  task automatic contend(input logic cpu_first);
    ask(1'b1, 4'h1, 3'h0);
    wait_start();
    `CHK(cpu_xfer_start_o, cpu_first)
    `CHK(dma_xfer_start_o[0], ~cpu_first)
    @(negedge sys_clk_i);
    wait_start();
    `CHK(cpu_xfer_start_o, ~cpu_first)
    `CHK(dma_xfer_start_o[0], cpu_first)
  endtask

  task automatic dma_chain();
    ask(1'b0, 4'b1010, 3'h0);
    wait_start();
    `CHK(dma_xfer_start_o, 4'b0010)
    `CHK(u_bus_if.dma_grant, 1'b1)
    `CHK(u_bus_if.dma_bus_request_n, 1'b0)
    `CHK(dma_busy_o, 4'b0010)
    @(negedge sys_clk_i);
    wait_start();
    `CHK(dma_xfer_start_o, 4'b1000)
  endtask

  // two idle refreshes: spacing and a dataless cycle
  task automatic refresh_period();
    for (i = 0; i < LIM && !u_bus_if.refresh_grant; i++) @(negedge sys_clk_i);
    give_up(i);
    `CHK({cpu_xfer_start_o, dma_xfer_start_o}, 5'h00)
    for (i = 0; i < LIM && u_bus_if.refresh_grant; i++) @(negedge sys_clk_i);
    give_up(i);
    n = i;
    for (i = 0; i < LIM && !u_bus_if.refresh_grant; i++) @(negedge sys_clk_i);
    give_up(i);
    `CHK(n + i, int'(REF))
  endtask

  task automatic abort_refresh();
    refresh_period();
    // non-blocking: the memory model still sees the old value at this edge
    mem_ok <= 1'b0;
    ask(1'b1, 4'h0, 3'h1);
    wait_start();
    ask(1'b0, 4'b0100, 3'h0);
    for (i = 0; i < LIM && !u_bus_if.bus_abort; i++) @(negedge sys_clk_i);
    give_up(i);
    `CHK(u_bus_if.internal_trap, 1'b1)
    `CHK(u_bus_if.cpu_grant, 1'b0)
    mem_ok <= 1'b1;
    @(negedge sys_clk_i);
    `CHK(u_bus_if.trap_level, sba_pkg::TRAP_LEVEL)
    `CHK(refresh_pending_o, 1'b1)
    for (i = 0; i < LIM && !u_bus_if.refresh_grant && !u_bus_if.dma_grant; i++)
      @(negedge sys_clk_i);
    give_up(i);
    `CHK(u_bus_if.refresh_grant, 1'b1)
    wait_start();
    `CHK(dma_xfer_start_o, 4'b0100)
  endtask

  initial begin
    reset_n_i = 1'b0;
    cpu_access_i = 1'b0;
    cpu_xfer_type_i = 3'h0;
    dma_need_i = 4'h0;
    mem_ok = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    repeat (8) @(negedge sys_clk_i);
    `CHK({u_bus_if.cpu_grant, u_bus_if.dma_grant, u_bus_if.refresh_grant}, 3'h0)
    `CHK(u_bus_if.trap_level, 4'h0)
    reset_n_i = 1'b1;
    contend(1'b0);
    refresh_period();
    contend(1'b1);
    for (int k = 0; k < 6; k++) cpu_word(k[2:0]);
    dma_chain();
    abort_refresh();
    stop_test();
  end
endmodule
